// ---- verilog/burst_bus_ctrl.sv ----
// Burst bus control: lane enables, burst-last, hold, init failure
//
// Contract
// - Sample lock pin during reset; low at release enters float mode.
// - In float mode every output stays high impedance until next reset.
// - Upper lane enable qualifies bits 15:8, lower enable bits 7:0.
// - Each data cycle enables only participating lanes, two at most.
// - Init failure shows burst-last asserted with both lane enables off.
// - Failure shows only after reset release, before first transaction.
// - Failure held during self-test, dropped when self-test passes.
// - After self-test read first eight words, sum must be zero.
// - Nonzero sum asserts failure again and keeps it asserted.
// - Zero sum continues initialisation with failure deasserted.
// - Grant: float bus lines, then raise acknowledge, then hold state.
// - Request removed: drop acknowledge, go to idle or address; here always to idle first.
// - Acknowledge driven except in float mode, low during reset.
// - Burst-last low in final data cycle and its wait cycles.
// - No ready in data cycle adds a wait cycle until ready.
// - Word address increments on each beat of a burst.
`timescale 1ns/1ps
`include "burst_bus_defs.svh"
module burst_bus_ctrl #(
    parameter int TEST_CYCLES = `SELF_TEST_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic lock_n_pin,
    input wire logic hold_req_pin,
    input wire logic ready_n_pin,
    input wire logic [15:0] read_data,
    input wire logic self_test_ok,
    input wire burst_bus_pkg::burst_req_t req,
    output logic req_ready,
    output logic init_done,
    output logic emulator_float_mode,
    output logic [1:0] byte_lane_enables_n,
    output logic [1:0] byte_lane_enables_oe,
    output logic burst_final_beat_n,
    output logic burst_final_beat_oe,
    output logic [2:0] burst_word_address,
    output logic burst_word_address_oe,
    output logic bus_grant_ack,
    output logic bus_grant_ack_oe,
    output logic bus_float
);
    burst_bus_pkg::bus_state_t st_r, st_nxt;
    burst_bus_pkg::init_state_t ini_r, ini_nxt;
    burst_bus_pkg::bus_pins_t pins_r, pins_nxt;
    logic lock_n_s, hold_s, ready_n_s;
    logic [7:0] test_cnt_r;
    logic [3:0] word_cnt_r;
    logic [15:0] sum_r;
    logic [1:0] beats_left_r;
    logic [1:0] lanes_r;
    logic [2:0] addr_r;
    logic float_r;
    logic rd_first_r;
    logic test_end, read_beat, last_beat, fail_show, grant, start;

    pin_sync #(.WIDTH(1)) u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .pin_in(ready_n_pin),
        .pin_out(ready_n_s)
    );
    // Hold request is active high, synchronised apart since it idles low
    logic hold_m_r;
    always_ff @(posedge core_clk)
    begin
        hold_m_r <= srst ? 1'b0 : hold_req_pin;
        hold_s <= srst ? 1'b0 : hold_m_r;
    end
    // Lock stages stay unreset: the pin must be seen while reset is applied
    logic lock_m_r;
    always_ff @(posedge core_clk)
    begin
        lock_m_r <= lock_n_pin;
        lock_n_s <= lock_m_r;
    end

    // Float latch: the lock level seen during reset is held, so the last
    // sampled value at release decides the mode
    logic lock_seen_r;
    always_ff @(posedge core_clk)
    begin
        if (srst)
            lock_seen_r <= lock_n_s;
        else
            lock_seen_r <= lock_seen_r;
    end
    logic srst_d_r;
    logic float_set;
    // Float entry decided on the first edge after release
    assign float_set = srst_d_r && !lock_seen_r;
    always_ff @(posedge core_clk)
    begin
        srst_d_r <= srst;
        if (srst)
            float_r <= 1'b0;
        else if (float_set)
            float_r <= 1'b1;
    end

    // Init sequencing decodes
    assign test_end = (test_cnt_r == 8'(TEST_CYCLES - 1));
    assign read_beat = (st_r == burst_bus_pkg::ST_DATA ||
                        st_r == burst_bus_pkg::ST_WAIT) && !ready_n_s;
    assign last_beat = (beats_left_r == 2'h0);
    assign grant = hold_s && (st_r == burst_bus_pkg::ST_IDLE ||
                              (st_r == burst_bus_pkg::ST_DATA ||
                               st_r == burst_bus_pkg::ST_WAIT) &&
                              read_beat && last_beat);
    // Failure only while no transaction has begun, or after a failed self-test or bad sum
    assign fail_show = (ini_r == burst_bus_pkg::INIT_TEST && rd_first_r) ||
                       ini_r == burst_bus_pkg::INIT_FAIL;
    assign start = st_r == burst_bus_pkg::ST_IDLE && !hold_s &&
                   (ini_r == burst_bus_pkg::INIT_READ ||
                    (ini_r == burst_bus_pkg::INIT_DONE && req.valid));

    // Init state machine
    always_comb
    begin
        ini_nxt = ini_r;
        unique case (ini_r)
            burst_bus_pkg::INIT_TEST:
                if (test_end)
                    ini_nxt = self_test_ok ? burst_bus_pkg::INIT_READ
                                           : burst_bus_pkg::INIT_FAIL;
            burst_bus_pkg::INIT_READ:
                if (read_beat && word_cnt_r == `CHECKSUM_WORDS - 4'h1)
                    ini_nxt = (16'(sum_r + read_data) == 16'h0000)
                              ? burst_bus_pkg::INIT_DONE
                              : burst_bus_pkg::INIT_FAIL;
            burst_bus_pkg::INIT_DONE:
                ini_nxt = ini_r;
            burst_bus_pkg::INIT_FAIL:
                ini_nxt = ini_r;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            ini_r <= burst_bus_pkg::INIT_TEST;
            test_cnt_r <= 8'h00;
            word_cnt_r <= 4'h0;
            sum_r <= 16'h0000;
            rd_first_r <= 1'b1;
        end
        else
        begin
            ini_r <= ini_nxt;
            if (ini_r == burst_bus_pkg::INIT_TEST && !test_end)
                test_cnt_r <= test_cnt_r + 8'h01;
            if (ini_r == burst_bus_pkg::INIT_READ && read_beat)
            begin
                word_cnt_r <= word_cnt_r + 4'h1;
                sum_r <= 16'(sum_r + read_data);
            end
            if (test_end)
                rd_first_r <= 1'b0;
        end
    end

    // Bus state machine; hold granted only between transfers
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            burst_bus_pkg::ST_IDLE:
                if (hold_s)
                    st_nxt = burst_bus_pkg::ST_FLOAT;
                else if (start)
                    st_nxt = burst_bus_pkg::ST_ADDR;
            burst_bus_pkg::ST_ADDR:
                st_nxt = burst_bus_pkg::ST_DATA;
            burst_bus_pkg::ST_DATA, burst_bus_pkg::ST_WAIT:
                if (!read_beat)
                    st_nxt = burst_bus_pkg::ST_WAIT;
                else if (!last_beat)
                    st_nxt = burst_bus_pkg::ST_DATA;
                else if (grant)
                    st_nxt = burst_bus_pkg::ST_FLOAT;
                else
                    st_nxt = burst_bus_pkg::ST_IDLE;
            burst_bus_pkg::ST_FLOAT:
                st_nxt = burst_bus_pkg::ST_HOLD;
            burst_bus_pkg::ST_HOLD:
                if (!hold_s)
                    st_nxt = start ? burst_bus_pkg::ST_ADDR
                                   : burst_bus_pkg::ST_IDLE;
            default:
                st_nxt = burst_bus_pkg::ST_IDLE;
        endcase
    end

    // Next beat values, shared by the trackers and the registered pins
    logic [1:0] beats_nxt, lanes_nxt;
    logic [2:0] addr_nxt;
    logic ld_burst, ld_init, step;
    assign ld_burst = st_r == burst_bus_pkg::ST_ADDR;
    assign ld_init = ini_r == burst_bus_pkg::INIT_READ;
    assign step = read_beat && !last_beat;
    assign beats_nxt = ld_burst ? (ld_init ? 2'h3 : req.beats_m1) :
                       step ? beats_left_r - 2'h1 : beats_left_r;
    assign lanes_nxt = ld_burst ? (ld_init ? 2'h3 : req.lanes) :
                       lanes_r;
    assign addr_nxt = ld_burst ?
                      (ld_init ? {word_cnt_r[2], 2'h0} : req.start_word) :
                      step ? 3'(addr_r + 3'h1) : addr_r;
    // Beat tracking; address advances per accepted beat
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            st_r <= burst_bus_pkg::ST_IDLE;
            beats_left_r <= 2'h0;
            lanes_r <= 2'h0;
            addr_r <= 3'h0;
        end
        else
        begin
            st_r <= st_nxt;
            beats_left_r <= beats_nxt;
            lanes_r <= lanes_nxt;
            addr_r <= addr_nxt;
        end
    end

    // Pin values, registered so each output comes from a flip-flop
    logic in_data;
    assign in_data = st_nxt == burst_bus_pkg::ST_DATA ||
                     st_nxt == burst_bus_pkg::ST_WAIT;
    always_comb
    begin
        pins_nxt.byte_lane_enables_n = 2'h3;
        pins_nxt.burst_final_beat_n = !fail_show;
        pins_nxt.burst_word_address = addr_nxt;
        pins_nxt.bus_grant_ack = st_nxt == burst_bus_pkg::ST_HOLD;
        // Pins show the coming cycle, so the first data cycle is enabled
        if (in_data)
        begin
            // Bit 1 upper lane 15:8, bit 0 lower lane 7:0
            pins_nxt.byte_lane_enables_n = ~lanes_nxt;
            pins_nxt.burst_final_beat_n = beats_nxt != 2'h0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            pins_r <= '{2'h3, 1'b1, 3'h0, 1'b0};
            bus_float <= 1'b1;
            req_ready <= 1'b0;
            init_done <= 1'b0;
        end
        else
        begin
            pins_r <= pins_nxt;
            // Lines float one cycle before acknowledge rises
            bus_float <= float_r || float_set ||
                         st_nxt == burst_bus_pkg::ST_FLOAT ||
                         st_nxt == burst_bus_pkg::ST_HOLD;
            req_ready <= start && ini_r == burst_bus_pkg::INIT_DONE;
            init_done <= ini_nxt == burst_bus_pkg::INIT_DONE;
        end
    end

    assign emulator_float_mode = float_r;
    assign byte_lane_enables_n = pins_r.byte_lane_enables_n;
    assign burst_final_beat_n = pins_r.burst_final_beat_n;
    assign burst_word_address = pins_r.burst_word_address;
    assign bus_grant_ack = pins_r.bus_grant_ack;
    // Acknowledge driven except in float mode; others float with the bus
    assign bus_grant_ack_oe = !float_r;
    assign byte_lane_enables_oe = {2{!bus_float}};
    assign burst_final_beat_oe = !bus_float;
    assign burst_word_address_oe = !bus_float;
endmodule

// ---- include/burst_bus_defs.svh ----
// Offsets-free constants for the burst bus control block
`ifndef BURST_BUS_DEFS_SVH
`define BURST_BUS_DEFS_SVH
`define CHECKSUM_WORDS 4'h8
`define SELF_TEST_CYCLES 8'h20
`define HOLD_FLOAT_CYCLES 2'h1
`endif

// ---- include/burst_bus_pkg.sv ----
// Types shared by the burst bus control block
package burst_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_WAIT,
        ST_FLOAT,
        ST_HOLD
    } bus_state_t;
    typedef enum logic [2:0] {
        INIT_TEST,
        INIT_READ,
        INIT_DONE,
        INIT_FAIL
    } init_state_t;
    // Core request for one burst
    typedef struct packed {
        logic valid;
        logic [2:0] start_word;
        logic [1:0] beats_m1;
        logic [1:0] lanes;
    } burst_req_t;
    // Pin-facing output group
    typedef struct packed {
        logic [1:0] byte_lane_enables_n;
        logic burst_final_beat_n;
        logic [2:0] burst_word_address;
        logic bus_grant_ack;
    } bus_pins_t;
endpackage

// ---- verilog/pin_sync.sv ----
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_r;
    // First stage feeds only the second; reset to all ones (inactive)
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            meta_r <= '1;
            pin_out <= '1;
        end
        else
        begin
            meta_r <= pin_in;
            pin_out <= meta_r;
        end
    end
endmodule

// ---- bench/burst_bus_ctrl_props.sv ----
// Assertion checker for the burst bus control block
`timescale 1ns/1ps
module burst_bus_ctrl_props (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic lock_n_pin,
    input wire logic hold_req_pin,
    input wire logic init_done,
    input wire logic emulator_float_mode,
    input wire logic [1:0] byte_lane_enables_n,
    input wire logic [1:0] byte_lane_enables_oe,
    input wire logic burst_final_beat_n,
    input wire logic burst_final_beat_oe,
    input wire logic [2:0] burst_word_address,
    input wire logic burst_word_address_oe,
    input wire logic bus_grant_ack,
    input wire logic bus_grant_ack_oe,
    input wire logic bus_float
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Lock low at release must lead into float mode quickly
    AST_FLOAT_LOCK: assert property ($fell(srst) && !$past(lock_n_pin, 2)
        |-> ##[0:2] emulator_float_mode) else $error("float mode missed");
    AST_FLOAT_OE: assert property (emulator_float_mode |->
        byte_lane_enables_oe == 2'h0 && !burst_final_beat_oe &&
        !burst_word_address_oe && !bus_grant_ack_oe)
        else $error("driving in float mode");
    AST_ACK_DRIVEN: assert property (!emulator_float_mode |->
        bus_grant_ack_oe) else $error("ack floated");
    // Checked straight through reset, so no disable here
    AST_ACK_RESET: assert property (disable iff (1'b0) $past(srst)
        |-> !bus_grant_ack) else $error("ack high in reset");
    AST_ACK_ORDER: assert property ($rose(bus_grant_ack) |->
        bus_float && $past(bus_float)) else $error("ack before float");
    AST_ACK_QUIET: assert property (bus_grant_ack |->
        byte_lane_enables_n == 2'h3) else $error("lanes active in hold");
    AST_ACK_DROP: assert property ($fell(hold_req_pin) ##1
        !hold_req_pin[*3] |-> !bus_grant_ack) else $error("ack stuck");
    AST_FAIL_PRE: assert property (!burst_final_beat_n &&
        byte_lane_enables_n == 2'h3 && burst_final_beat_oe |-> !init_done)
        else $error("failure after init");
    AST_ADDR_INC: assert property ($changed(burst_word_address) &&
        byte_lane_enables_n != 2'h3 && $past(byte_lane_enables_n) != 2'h3
        |-> burst_word_address == $past(burst_word_address) + 3'h1)
        else $error("address step wrong");
endmodule

// ---- bench/burst_mem_model.sv ----
// Memory partner: answers beats with ready and the addressed word
`timescale 1ns/1ps
module burst_mem_model (
    input wire logic core_clk,
    input wire logic slow,
    input wire logic [1:0] byte_lane_enables_n,
    input wire logic [2:0] burst_word_address,
    output logic ready_n_pin,
    output logic [15:0] read_data
);
    logic [15:0] mem [8];
    logic [15:0] junk_r = 16'hA5A5;
    int seed = 25;
    // Slow mode stalls at random so wait cycles really occur
    always @(posedge core_clk)
    begin
        ready_n_pin <= slow ? 1'($random(seed)) : 1'b0;
        junk_r <= ~junk_r;
    end
    // Off-beat data toggles so a stale sample never matches by luck
    assign read_data = (byte_lane_enables_n != 2'h3) ?
        mem[burst_word_address] : junk_r;
endmodule

// ---- bench/burst_bus_ctrl_tb_top.sv ----
// Testbench top for the burst bus control block
`timescale 1ns/1ps
module burst_bus_ctrl_tb_top;
    logic core_clk = 0, srst = 1, lock_n_pin = 1, hold_req_pin = 0;
    logic self_test_ok = 1, slow = 0, seen = 0;
    logic ready_n_pin, req_ready, init_done, emulator_float_mode;
    logic [15:0] read_data, sum;
    logic [1:0] byte_lane_enables_n, byte_lane_enables_oe;
    logic burst_final_beat_n, burst_final_beat_oe, burst_word_address_oe;
    logic [2:0] burst_word_address;
    logic bus_grant_ack, bus_grant_ack_oe, bus_float;
    burst_bus_pkg::burst_req_t req = '0;
    logic [4:0] q [$];
    int err_count = 0, compares = 0, seed = 25, n;
    always #12.5 core_clk = ~core_clk;
    burst_bus_ctrl #(.TEST_CYCLES(8)) u_burst_bus_ctrl (.*);
    burst_mem_model u_burst_mem_model (.*);
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task test_done;
        $display("errors %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function logic lvl(int k);
        return k == 0 ? init_done : k == 1 ? bus_grant_ack : req_ready;
    endfunction
    // Bounded wait for a design flag to reach a level
    task wait_lvl(input int k, input logic v);
        n = 0;
        while (lvl(k) !== v)
        begin
            @(posedge core_clk);
            if (++n > 2000)
            begin
                chk("wait", 8'h1, 8'h0);
                test_done();
            end
        end
    endtask
    // Reset with a given lock level; init reads expect both lanes
    task rst(input logic lk, input logic init);
        srst <= 1;
        lock_n_pin <= lk;
        repeat (20) @(posedge core_clk);
        if (init)
            q = '{5'h3, 5'h7};
        srst <= 0;
        repeat (4) @(posedge core_clk);
        lock_n_pin <= 1;
    endtask
    // Final beat of every burst: lanes and end address against notes
    always @(negedge core_clk)
    begin
        if (!srst && burst_final_beat_n === 0 && byte_lane_enables_n != 3)
        begin
            if (!seen)
                chk("final", q.size() ? q.pop_front() : 5'h1F,
                    {byte_lane_enables_n, burst_word_address});
            seen = 1;
        end
        else
            seen = 0;
    end
    initial
    begin
        sum = 0;
        for (int i = 0; i < 7; i++)
        begin
            u_burst_mem_model.mem[i] = $random(seed);
            sum += u_burst_mem_model.mem[i];
        end
        u_burst_mem_model.mem[7] = -sum;
        rst(1, 1);
        chk("fail", 8'h06, {byte_lane_enables_n, burst_final_beat_n});
        wait_lvl(0, 1);
        chk("ok", 8'h0F, {byte_lane_enables_n, burst_final_beat_n,
            init_done});
        slow <= 1;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge core_clk);
            req <= {1'b1, 3'($random(seed)), 2'($random(seed)),
                    2'(i % 3 + 1)};
            @(posedge core_clk);
            q.push_back({~req.lanes, 3'(req.start_word + req.beats_m1)});
            wait_lvl(2, 1);
            req.valid <= 0;
            wait_lvl(2, 0);
        end
        repeat (40) @(posedge core_clk);
        hold_req_pin <= 1;
        wait_lvl(1, 1);
        chk("hold", 8'h1, {byte_lane_enables_oe, bus_float});
        hold_req_pin <= 0;
        wait_lvl(1, 0);
        u_burst_mem_model.mem[7] += 16'h1;
        rst(1, 1);
        repeat (600) @(posedge core_clk);
        chk("bad", 8'h0C, {byte_lane_enables_n, burst_final_beat_n,
            init_done});
        rst(0, 0);
        chk("float", 8'h01, {byte_lane_enables_oe, burst_final_beat_oe,
            bus_grant_ack_oe, emulator_float_mode});
        chk("queue", 8'h0, 8'(q.size()));
        test_done();
    end
endmodule
bind burst_bus_ctrl burst_bus_ctrl_props u_props (.*);
